// *** rtl/uie_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module uie_top #(
  parameter int LVL_W = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wdata,
  input wire logic enh_enable,
  input wire logic bit_tick,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] rx_trigger,
  input wire logic rx_push,
  input wire logic rx_overrun,
  input wire logic [2:0] rx_err_new,
  input wire logic [2:0] rx_err_head,
  input wire logic rx_fifo_err,
  input wire logic [LVL_W-1:0] tx_level,
  input wire logic [LVL_W-1:0] tx_trigger,
  input wire logic tx_shift_empty,
  input wire logic half_duplex,
  input wire logic [3:0] modem_delta,
  input wire logic [3:0] modem_lines,
  input wire logic xoff_match,
  input wire logic xon_match,
  input wire logic special_match,
  input wire logic rts_rise,
  input wire logic cts_rise,
  input wire logic wake_event,
  output logic [7:0] rdata_ff,
  output logic irq_ff,
  output logic [7:0] interrupt_enable_ff,
  output logic fifo_enable_ff
);
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_LINE = 3'b001,
    SRC_TIMEOUT = 3'b010,
    SRC_RX = 3'b011,
    SRC_TX = 3'b100,
    SRC_MODEM = 3'b101,
    SRC_XOFF = 3'b110,
    SRC_FLOW = 3'b111
  } uie_src_e;

  logic ls_timing_ff;
  logic [7:0] nxt_rdata;
  logic thr_empty_ff;
  logic tx_armed_ff;
  logic [3:0] delta_ff;
  logic xoff_ff;
  logic special_ff;
  logic wake_ff;
  logic [uie_pkg::TIMER_W-1:0] timer_ff;
  logic timeout_ff;
  logic tx_prev_ff;
  uie_src_e cur_src; // declared early: clear paths read it before the pick
  // bus strobes
  wire rd_isr = rd_stb && (addr == uie_pkg::ADDR_INTERRUPT_STATUS);
  wire rd_lsr = rd_stb && (addr == uie_pkg::ADDR_LINE_STATUS);
  wire rd_msr = rd_stb && (addr == uie_pkg::ADDR_MODEM_STATUS);
  wire rd_rhr = rd_stb && (addr == uie_pkg::ADDR_DATA);
  wire wr_thr = wr_stb && (addr == uie_pkg::ADDR_DATA);
  wire wr_ier = wr_stb && (addr == uie_pkg::ADDR_INTERRUPT_ENABLE);
  wire wr_fcr = wr_stb && (addr == uie_pkg::ADDR_FIFO_CONTROL);
  wire wr_xfr = wr_stb && (addr == uie_pkg::ADDR_EXTRA_FEATURE) && enh_enable;

  // enable bits that take effect
  wire [3:0] upper_en = interrupt_enable_ff[7:4] & {4{enh_enable}};

  // receive side conditions
  wire rx_empty = (rx_level == '0);
  wire rx_at_trigger = fifo_enable_ff ? (rx_level >= rx_trigger)
                                      : !rx_empty;
  wire data_ready = !rx_empty;
  wire [2:0] byte_err = ls_timing_ff ? rx_err_new : rx_err_head;

  // line status flags (sticky until line status read)
  logic ovr_ff;
  logic [2:0] err_ff;
  wire line_pend = ovr_ff || (err_ff != 3'b000);

  uie_edge_catch u_ovr (
    .clk(clk),
    .resetn(resetn),
    .set_i(rx_overrun),
    .clr_i(rd_lsr),
    .flag_ff(ovr_ff)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_err
      uie_edge_catch u_err (
        .clk(clk),
        .resetn(resetn),
        .set_i(byte_err[gi]),
        .clr_i(rd_lsr),
        .flag_ff(err_ff[gi])
      );
    end
  endgenerate

  // transmit condition: trigger, fifo empty, or whole transmitter empty
  wire tx_fifo_empty = (tx_level == '0);
  wire tx_cond = half_duplex ? (tx_fifo_empty && tx_shift_empty)
               : fifo_enable_ff ? (tx_level < tx_trigger) || tx_fifo_empty
               : tx_fifo_empty;

  // time-out timer: 4 chars of 10 bits plus 12 bits, restarted by activity
  localparam logic [uie_pkg::TIMER_W-1:0] TIMEOUT_BITS = uie_pkg::TIMER_W'(
    uie_pkg::TIMEOUT_CHARS * 10 + uie_pkg::TIMEOUT_EXTRA_BITS);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      timer_ff <= '0;
    else if (rx_push || rd_rhr || rx_empty)
      timer_ff <= '0;
    else if (bit_tick && timer_ff != TIMEOUT_BITS)
      timer_ff <= timer_ff + 1'b1;
  end

  // time-out flag, cleared by a data read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      timeout_ff <= 1'b0;
    else if (fifo_enable_ff && bit_tick && timer_ff == TIMEOUT_BITS - 1'b1)
      timeout_ff <= 1'b1;
    else if (rd_rhr)
      timeout_ff <= 1'b0;
  end

  // transmit ready: armed on rising condition or on enable write
  wire tx_en_rise = wr_ier && wdata[1] && !interrupt_enable_ff[1];
  wire tx_set = (tx_cond && !tx_prev_ff) || (tx_en_rise && tx_cond);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_prev_ff <= 1'b0;
      tx_armed_ff <= 1'b0;
    end
    else
    begin
      tx_prev_ff <= tx_cond;
      if (tx_set)
        tx_armed_ff <= 1'b1;
      else if ((rd_isr && cur_src == SRC_TX) || wr_thr || !tx_cond)
        tx_armed_ff <= 1'b0;
    end
  end

  // modem deltas, cleared by modem status read
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_delta
      uie_edge_catch u_delta (
        .clk(clk),
        .resetn(resetn),
        .set_i(modem_delta[gi]),
        .clr_i(rd_msr),
        .flag_ff(delta_ff[gi])
      );
    end
  endgenerate

  // xoff and special: cleared by status read; xoff also by xon, special also by next char
  uie_edge_catch u_xoff (
    .clk(clk),
    .resetn(resetn),
    .set_i(xoff_match && enh_enable),
    .clr_i((rd_isr && cur_src == SRC_XOFF) || xon_match),
    .flag_ff(xoff_ff)
  );
  uie_edge_catch u_special (
    .clk(clk),
    .resetn(resetn),
    .set_i(special_match && enh_enable),
    .clr_i((rd_isr && cur_src == SRC_XOFF) || (rx_push && !special_match)),
    .flag_ff(special_ff)
  );

  // rts/cts change, cleared only by modem status read
  logic rts_ff;
  logic cts_ff;
  uie_edge_catch u_rts (
    .clk(clk),
    .resetn(resetn),
    .set_i(rts_rise),
    .clr_i(rd_msr),
    .flag_ff(rts_ff)
  );
  uie_edge_catch u_cts (
    .clk(clk),
    .resetn(resetn),
    .set_i(cts_rise),
    .clr_i(rd_msr),
    .flag_ff(cts_ff)
  );

  // wake-up indicator, cleared by status read
  uie_edge_catch u_wake (
    .clk(clk),
    .resetn(resetn),
    .set_i(wake_event && upper_en[0]),
    .clr_i(rd_isr),
    .flag_ff(wake_ff)
  );

  // pending sources gated by enables
  wire p_line = interrupt_enable_ff[2] && line_pend;
  wire p_tmo = interrupt_enable_ff[0] && timeout_ff;
  wire p_rx = interrupt_enable_ff[0] && rx_at_trigger;
  wire p_tx = interrupt_enable_ff[1] && tx_armed_ff;
  wire p_modem = interrupt_enable_ff[3] && (delta_ff != 4'h0);
  wire p_xoff = upper_en[1] && (xoff_ff || special_ff);
  wire p_flow = (upper_en[2] && rts_ff) || (upper_en[3] && cts_ff);

  // priority pick, highest first
  assign cur_src = p_line ? SRC_LINE
                 : p_tmo ? SRC_TIMEOUT
                 : p_rx ? SRC_RX
                 : p_tx ? SRC_TX
                 : p_modem ? SRC_MODEM
                 : p_xoff ? SRC_XOFF
                 : p_flow ? SRC_FLOW
                 : SRC_NONE;

  function automatic logic [5:0] src_code(input uie_src_e s);
    unique case (s)
      SRC_LINE: src_code = uie_pkg::CODE_LINE;
      SRC_TIMEOUT: src_code = uie_pkg::CODE_TIMEOUT;
      SRC_RX: src_code = uie_pkg::CODE_RX_DATA;
      SRC_TX: src_code = uie_pkg::CODE_TX_READY;
      SRC_MODEM: src_code = uie_pkg::CODE_MODEM;
      SRC_XOFF: src_code = uie_pkg::CODE_XOFF;
      SRC_FLOW: src_code = uie_pkg::CODE_FLOW;
      SRC_NONE: src_code = uie_pkg::CODE_NONE;
    endcase
  endfunction : src_code

  // status and line status words
  wire [7:0] isr_word = {{2{fifo_enable_ff}}, src_code(cur_src)};
  wire [7:0] lsr_word = {rx_fifo_err, tx_fifo_empty && tx_shift_empty,
                         tx_fifo_empty, err_ff, ovr_ff, data_ready};
  wire [7:0] msr_word = {modem_lines, delta_ff};

  // read data mux
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (rd_stb)
    begin
      unique case (addr)
        uie_pkg::ADDR_INTERRUPT_ENABLE: nxt_rdata = interrupt_enable_ff;
        uie_pkg::ADDR_INTERRUPT_STATUS: nxt_rdata = isr_word;
        uie_pkg::ADDR_LINE_STATUS: nxt_rdata = lsr_word;
        uie_pkg::ADDR_MODEM_STATUS: nxt_rdata = msr_word;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // registers written by the host
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      interrupt_enable_ff <= uie_pkg::INTERRUPT_ENABLE_RST;
      fifo_enable_ff <= uie_pkg::FIFO_ENABLE_RST;
      ls_timing_ff <= uie_pkg::LS_TIMING_RST;
    end
    else
    begin
      if (wr_ier)
      begin
        interrupt_enable_ff[3:0] <= wdata[3:0];
        if (enh_enable)
          interrupt_enable_ff[7:4] <= wdata[7:4];
      end
      if (wr_fcr)
        fifo_enable_ff <= wdata[uie_pkg::FIFO_ENABLE_BIT];
      if (wr_xfr)
        ls_timing_ff <= wdata[uie_pkg::LS_TIMING_BIT];
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      irq_ff <= (cur_src != SRC_NONE);
    end
  end

  chk_irq_follows: assert property (@(posedge clk) disable iff (!resetn)
    (cur_src != SRC_NONE) |=> irq_ff) else $error("irq missing");
  chk_isr_fifo_bits: assert property (@(posedge clk) disable iff (!resetn)
    rd_isr |=> rdata_ff[7:6] == {2{$past(fifo_enable_ff)}})
    else $error("fifo bits wrong");
  chk_line_prio: assert property (@(posedge clk) disable iff (!resetn)
    (rd_isr && p_line) |=> rdata_ff[5:0] == uie_pkg::CODE_LINE)
    else $error("line not first");
  chk_none_code: assert property (@(posedge clk) disable iff (!resetn)
    (rd_isr && cur_src == SRC_NONE) |=> rdata_ff[0])
    else $error("idle bit 0 low");
  chk_flow_kept: assert property (@(posedge clk) disable iff (!resetn)
    (rts_ff && !rd_msr) |=> rts_ff) else $error("rts flag lost");
  chk_upper_gate: assert property (@(posedge clk) disable iff (!resetn)
    (wr_ier && !enh_enable) |=> $stable(interrupt_enable_ff[7:4]))
    else $error("upper enables written");
  chk_tx_clear: assert property (@(posedge clk) disable iff (!resetn)
    (wr_thr && !tx_set) |=> !tx_armed_ff) else $error("tx not cleared");
  chk_modem_clr: assert property (@(posedge clk) disable iff (!resetn)
    (rd_msr && modem_delta == 4'h0) |=> delta_ff == 4'h0)
    else $error("delta not cleared");
  chk_ready_flag: assert property (@(posedge clk) disable iff (!resetn)
    (rd_lsr && rx_level != '0) |=> rdata_ff[0]) else $error("ready low");
  cov_line: cover property (@(posedge clk) rd_isr && p_line);
  cov_timeout: cover property (@(posedge clk) timeout_ff);
  cov_flow: cover property (@(posedge clk) rd_isr && cur_src == SRC_FLOW);
endmodule : uie_top
`default_nettype wire

// *** rtl/uie_pkg.sv ***
package uie_pkg;
  // register addresses on the 3-bit bus (A2..A0)
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_INTERRUPT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_INTERRUPT_STATUS = 3'h2;
  localparam logic [2:0] ADDR_FIFO_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [2:0] ADDR_EXTRA_FEATURE = 3'h5;
  // reset values
  localparam logic [7:0] INTERRUPT_ENABLE_RST = 8'h00;
  localparam logic FIFO_ENABLE_RST = 1'b0;
  localparam logic LS_TIMING_RST = 1'b0;
  // field positions
  localparam int FIFO_ENABLE_BIT = 0;
  localparam int LS_TIMING_BIT = 3;
  localparam int ENH_ENABLE_BIT = 4;
  // status codes in bits 5..0
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
  localparam logic [5:0] CODE_RX_DATA = 6'h04;
  localparam logic [5:0] CODE_TX_READY = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_FLOW = 6'h20;
  localparam logic [5:0] CODE_NONE = 6'h01;
  // receive time-out: four characters plus this many bits
  localparam int TIMEOUT_CHARS = 4;
  localparam int TIMEOUT_EXTRA_BITS = 12;
  localparam int FIFO_DEPTH = 32;
  // timer counts enables of bit time; width covers 4*10+12 bits
  localparam int TIMER_W = 7;
endpackage : uie_pkg

// *** rtl/uie_edge_catch.sv ***
`timescale 1ns/1ps
`default_nettype none
// sticky event bit; set wins over clear
module uie_edge_catch (
  input wire logic clk,
  input wire logic resetn,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_ff
);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag_ff <= 1'b0;
    else if (set_i)
      flag_ff <= 1'b1;
    else if (clr_i)
      flag_ff <= 1'b0;
  end
endmodule : uie_edge_catch
`default_nettype wire

// *** verif/uie_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side of the 8-bit register bus
module uie_host_model (
  input wire logic clk,
  output logic [2:0] addr,
  output logic rd_stb,
  output logic wr_stb,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata_ff
);
  // bus idle, strobes low
  initial
  begin
    addr = 3'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wdata = 8'h00;
  end
  // one strobe cycle; read data lands on the edge that takes it
  task automatic xfer(input logic rd, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    addr = a;
    wdata = d;
    rd_stb = rd;
    wr_stb = !rd;
    @(negedge clk);
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wdata = ~d; // data not held after the strobe
    q = rdata_ff;
  endtask : xfer
endmodule : uie_host_model
`default_nettype wire

// *** verif/uie_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module uie_top_tb_top;
  logic clk, resetn, enh_enable, bit_tick, rx_push, rx_overrun, rx_fifo_err;
  logic tx_shift_empty, half_duplex, xoff_match, xon_match, special_match;
  logic rts_rise, cts_rise, wake_event, rd_stb, wr_stb, irq_ff, fifo_enable_ff;
  logic [5:0] rx_level, rx_trigger, tx_level, tx_trigger;
  logic [2:0] addr, rx_err_new, rx_err_head;
  logic [3:0] modem_delta, modem_lines;
  logic [7:0] wdata, rdata_ff, interrupt_enable_ff;
  int miscompares = 0;
  int comparisons = 0;
  uie_top i_uie_top (.clk(clk), .resetn(resetn), .addr(addr),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata),
    .enh_enable(enh_enable), .bit_tick(bit_tick), .rx_level(rx_level),
    .rx_trigger(rx_trigger), .rx_push(rx_push), .rx_overrun(rx_overrun),
    .rx_err_new(rx_err_new), .rx_err_head(rx_err_head),
    .rx_fifo_err(rx_fifo_err), .tx_level(tx_level), .tx_trigger(tx_trigger),
    .tx_shift_empty(tx_shift_empty), .half_duplex(half_duplex),
    .modem_delta(modem_delta), .modem_lines(modem_lines),
    .xoff_match(xoff_match), .xon_match(xon_match),
    .special_match(special_match), .rts_rise(rts_rise),
    .cts_rise(cts_rise), .wake_event(wake_event), .rdata_ff(rdata_ff),
    .irq_ff(irq_ff), .interrupt_enable_ff(interrupt_enable_ff),
    .fifo_enable_ff(fifo_enable_ff));
  uie_host_model i_uie_host_model (.clk(clk), .addr(addr), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .wdata(wdata), .rdata_ff(rdata_ff));
  // clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_uie_host_model.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_uie_host_model.xfer(1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic rd_any(input logic [2:0] a);
    logic [7:0] q;
    i_uie_host_model.xfer(1'b1, a, 8'h00, q);
  endtask : rd_any
  // a one-cycle pulse, then time for the request to settle
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // reset state and refused enable bits
  task automatic t_reset_and_enables;
    rd(3'h2, 8'h01);
    chk({7'h00, fifo_enable_ff}, 8'h00);
    wr(3'h1, 8'hf0);
    chk(interrupt_enable_ff, 8'h00);
  endtask : t_reset_and_enables
  // transmit ready fires on enable while empty, cleared by status read
  task automatic t_tx_ready;
    wr(3'h1, 8'h02);
    repeat (3) @(negedge clk);
    chk({7'h00, irq_ff}, 8'h01);
    rd(3'h2, 8'h02);
    repeat (2) @(negedge clk);
    chk({7'h00, irq_ff}, 8'h00);
    wr(3'h1, 8'h00);
  endtask : t_tx_ready
  // fifo mode: trigger, line status priority, time-out
  task automatic t_fifo_rx;
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h05);
    rx_level = 6'h08;
    repeat (3) @(negedge clk);
    rd(3'h2, 8'hc4);
    pulse(rx_overrun);
    rd(3'h2, 8'hc6);
    rd_any(3'h5);
    rd(3'h2, 8'hc4);
    rx_level = 6'h07;
    repeat (3) @(negedge clk);
    rd(3'h2, 8'hc1);
    chk({7'h00, irq_ff}, 8'h00);
    repeat (60) pulse(bit_tick);
    rd(3'h2, 8'hcc);
    rd_any(3'h0);
    rd(3'h2, 8'hc1);
    wr(3'h2, 8'h00);
    rd(3'h2, 8'h04);
  endtask : t_fifo_rx
  // modem delta raises, modem status read clears
  task automatic t_modem;
    wr(3'h1, 8'h08);
    @(negedge clk);
    modem_delta = 4'h4;
    @(negedge clk);
    modem_delta = 4'h0;
    repeat (3) @(negedge clk);
    rd(3'h2, 8'h00);
    rd_any(3'h6);
    rd(3'h2, 8'h01);
  endtask : t_modem
  // enhanced sources: xoff over flow change, flow cleared by modem read
  task automatic t_enhanced;
    enh_enable = 1'b1;
    wr(3'h1, 8'he0);
    chk(interrupt_enable_ff, 8'he0);
    pulse(xoff_match);
    pulse(rts_rise);
    rd(3'h2, 8'h10);
    rd(3'h2, 8'h20);
    rd(3'h2, 8'h20);
    rd_any(3'h6);
    rd(3'h2, 8'h01);
    pulse(cts_rise);
    rd(3'h2, 8'h20);
    rd_any(3'h6);
  endtask : t_enhanced
  // error timing: head errors by default, new errors once timing bit set
  task automatic t_errors;
    wr(3'h1, 8'h04);
    @(negedge clk);
    rx_err_new = 3'h1;
    @(negedge clk);
    rx_err_new = 3'h0;
    repeat (2) @(negedge clk);
    rd(3'h2, 8'h01);
    rx_err_head = 3'h2;
    @(negedge clk);
    rx_err_head = 3'h0;
    repeat (2) @(negedge clk);
    rd(3'h2, 8'h06);
    rd(3'h5, 8'h29);
    rd(3'h2, 8'h01);
    wr(3'h5, 8'h08);
    @(negedge clk);
    rx_err_new = 3'h1;
    @(negedge clk);
    rx_err_new = 3'h0;
    repeat (2) @(negedge clk);
    rd(3'h2, 8'h06);
    rd_any(3'h5);
  endtask : t_errors
  // inputs at time zero, reset, scenarios
  initial
  begin
    {enh_enable, bit_tick, rx_push, rx_overrun, rx_fifo_err} = '0;
    {tx_shift_empty, half_duplex, xoff_match, xon_match} = '0;
    {special_match, rts_rise, cts_rise, wake_event} = '0;
    {rx_level, tx_level, rx_err_new, rx_err_head, modem_delta} = '0;
    rx_trigger = 6'h08;
    tx_trigger = 6'h01;
    modem_lines = 4'h0;
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_reset_and_enables;
    t_tx_ready;
    t_fifo_rx;
    t_modem;
    t_enhanced;
    t_errors;
    close_out;
  end
  // watchdog, well beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule : uie_top_tb_top
`default_nettype wire
